// >>> common/dcr_pkg.sv
// shared constants and types of the display control and reset block
package dcr_pkg;
   localparam int CLK_NS = 8;
   localparam int CLR_TIME_NS = 110000; // least clear or reset time
   localparam logic [1:0] CLR_TICKS = 2'd3; // display clocks per clear or reset
   localparam int DCLK_CYC = (CLR_TIME_NS + CLR_TICKS * CLK_NS - 1) / (CLR_TICKS * CLK_NS);
   localparam int FLASH_DIV = 28672; // display clocks per flash or blink period
   localparam int ST_TICKS = 262144; // display clocks per self test
   localparam int DIGITS = 8;
   localparam int ADDR_W = 5;
   // control word fields
   localparam int CW_CLEAR = 7;
   localparam int CW_ST = 6;
   localparam int CW_RES = 5;
   localparam int CW_BLINK = 4;
   localparam int CW_FLASH = 3;
   localparam int CW_BR_LSB = 0;
   localparam logic [7:0] CW_RESET = 8'h00;
   localparam logic [2:0] BR_BLANK = 3'h7;
   localparam logic ST_PASS = 1'b1;
   localparam logic [6:0] SPACE_CODE = 7'h20;
   // pin decode of a4 a3 with the flash select high
   localparam logic [1:0] SEL_CHAR = 2'h3;
   localparam logic [1:0] SEL_CW = 2'h2;
   // host registers on axi4-lite
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0c;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_FLN = 13;
   localparam int CMD_READ = 16;
   localparam logic CTRL_RESET_VAL = 1'b1;
   localparam logic [31:0] STROBE_CYC = 32'h4;
   localparam int HOLD_CYC = (CLR_TICKS + 1) * DCLK_CYC;
   localparam int ST_HOLD_CYC = (ST_TICKS + CLR_TICKS + 1) * DCLK_CYC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef logic [DIGITS-1:0][6:0] dcr_chars_t;
endpackage : dcr_pkg

// >>> common/dcr_bus_if.sv
// parallel display bus between the host controller and the display
`timescale 1ns/1ns
interface dcr_bus_if;
   logic rst_n;
   logic ce_n;
   logic wr_n;
   logic rd_n;
   logic flash_ram_select_n;
   logic [4:0] addr;
   logic [7:0] host_dq_out;
   logic host_dq_oe;
   logic [7:0] dev_dq_out;
   logic dev_dq_oe;
   logic [7:0] data_bus;
   // wire level of the shared data lines, pulled high when nobody drives
   assign data_bus = dev_dq_oe ? dev_dq_out : (host_dq_oe ? host_dq_out : 8'hff);
   modport device(
      input rst_n, ce_n, wr_n, rd_n, flash_ram_select_n, addr, data_bus,
      output dev_dq_out, dev_dq_oe
   );
   modport host(
      output rst_n, ce_n, wr_n, rd_n, flash_ram_select_n, addr, host_dq_out, host_dq_oe,
      input data_bus
   );
endinterface : dcr_bus_if

// >>> core/dcr_device.sv
// display end: control word, rams, clear, reset and flash timing
//
// How it works
// - clear bit fills spaces, zeroes flash ram
// - clear finishes within three display clocks
// - host stays off bus during clear
// - clear bit returns to zero itself
// - brightness code decodes to eight levels
// - blink all digits, overrides flashing
// - control word write clears on bit seven
// - reset clears rams and control word
// - reset restarts internal timing counters
// - reset sequence lasts three display clocks
// - host stays off bus after reset
// - host strobes idle while reset low
// - host resets display at power up
// - common clock and reset synchronise displays
// - character write stores ascii by digit
// - control word decode a4 high a3 low
// - flash enable flashes marked digits only
// - flash rate is clock over 28672
`timescale 1ns/1ns
module dcr_device #(
   parameter int DCLK_DIV = dcr_pkg::DCLK_CYC,
   parameter int FLASH_PERIOD = dcr_pkg::FLASH_DIV,
   parameter int SELFTEST_TICKS = dcr_pkg::ST_TICKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   dcr_bus_if.device dbus,
   output dcr_pkg::dcr_chars_t digit_chars,
   output logic [dcr_pkg::DIGITS-1:0] digit_on,
   output logic [6:0] bright_pct,
   output logic busy,
   output logic selftest_run
);
   import dcr_pkg::*;

   typedef struct packed {
      logic [15:0] div;
      logic [14:0] ph_cnt;
      logic phase_off;
      logic [1:0] busy_cnt;
      logic [18:0] st_cnt;
      logic st_run;
      logic [7:0] cw;
      dcr_chars_t chars;
      logic [DIGITS-1:0] flash;
      logic wr_d;
      logic [7:0] dout;
      logic doe;
      logic [DIGITS-1:0] on;
      logic [6:0] pct;
   } dcr_dev_s;

   ////////////////////////////////////////////////////////////////
   // helpers

   // state after either reset: blanks, cleared flash, busy for three ticks
   function automatic dcr_dev_s rst_state();
      dcr_dev_s s;
      s = '0;
      s.cw = CW_RESET;
      s.chars = {DIGITS{SPACE_CODE}};
      s.busy_cnt = CLR_TICKS;
      s.wr_d = 1'b1;
      return s;
   endfunction : rst_state

   // brightness code to percent of full drive
   function automatic logic [6:0] pct_of(input logic [2:0] code);
      logic [6:0] p;
      p = 7'h00;
      unique case (code)
         3'h0: p = 7'd100;
         3'h1: p = 7'd80;
         3'h2: p = 7'd53;
         3'h3: p = 7'd40;
         3'h4: p = 7'd27;
         3'h5: p = 7'd20;
         3'h6: p = 7'd13;
         3'h7: p = 7'd0;
      endcase
      return p;
   endfunction : pct_of

   localparam dcr_dev_s RST_ST = rst_state();

   dcr_dev_s st;
   dcr_dev_s next_st;
   logic dtick;
   logic busy_now;
   logic acc;
   logic [2:0] dig;
   logic [7:0] d;

   ////////////////////////////////////////////////////////////////
   // next state

   // one process for every field; the pin reset overrides all at the end
   always_comb begin
      next_st = st;
      dig = dbus.addr[2:0];
      d = dbus.data_bus;
      busy_now = (st.busy_cnt != 2'h0) || st.st_run;
      dtick = (st.div == 16'(DCLK_DIV - 1));
      next_st.div = dtick ? 16'h0000 : st.div + 16'h0001;
      next_st.wr_d = dbus.wr_n;

      // flash and blink phase flips every half period
      if (dtick) begin
         if (st.ph_cnt == 15'(FLASH_PERIOD / 2 - 1)) begin
            next_st.ph_cnt = 15'h0000;
            next_st.phase_off = ~st.phase_off;
         end else begin
            next_st.ph_cnt = st.ph_cnt + 15'h0001;
         end
      end

      // clear and reset hold-off, counted in display clocks
      if (dtick && (st.busy_cnt != 2'h0)) begin
         next_st.busy_cnt = st.busy_cnt - 2'h1;
         if (st.busy_cnt == 2'h1) begin
            next_st.cw[CW_CLEAR] = 1'b0;
         end
      end

      // self test; the rom check has no failing path here, so it passes
      if (dtick && st.st_run) begin
         if (st.st_cnt == 19'(SELFTEST_TICKS - 1)) begin
            next_st.st_run = 1'b0;
            next_st.chars = {DIGITS{SPACE_CODE}};
            next_st.flash = '0;
            next_st.cw = CW_RESET;
            next_st.cw[CW_RES] = ST_PASS;
         end else begin
            next_st.st_cnt = st.st_cnt + 19'h00001;
         end
      end

      // a write is taken once, on the first cycle the strobe is seen low
      acc = !dbus.ce_n && dbus.rst_n && !busy_now;
      if (acc && st.wr_d && !dbus.wr_n && dbus.rd_n) begin
         if (!dbus.flash_ram_select_n) begin
            next_st.flash[dig] = d[0];
         end else if ((dbus.addr[4:3] == SEL_CHAR) && !d[7]) begin
            next_st.chars[dig] = d[6:0];
         end else if (dbus.addr[4:3] == SEL_CW) begin
            // the result bit is read only, a written value is dropped
            next_st.cw = {d[7:6], st.cw[CW_RES], d[4:0]};
            if (d[CW_CLEAR]) begin
               next_st.chars = {DIGITS{SPACE_CODE}};
               next_st.flash = '0;
               next_st.busy_cnt = CLR_TICKS;
            end
            if (d[CW_ST]) begin
               next_st.st_run = 1'b1;
               next_st.st_cnt = 19'h00000;
            end
         end
      end

      // read data, registered; unmapped selects read as zero
      next_st.doe = acc && !dbus.rd_n;
      if (!dbus.flash_ram_select_n) begin
         next_st.dout = {7'h00, st.flash[dig]};
      end else if (dbus.addr[4:3] == SEL_CHAR) begin
         next_st.dout = {1'b0, st.chars[dig]};
      end else if (dbus.addr[4:3] == SEL_CW) begin
         next_st.dout = st.cw;
      end else begin
         next_st.dout = 8'h00;
      end

      // digit visibility: blink covers all digits, flash the marked ones
      for (int i = 0; i < DIGITS; i++) begin
         next_st.on[i] = (st.cw[CW_BR_LSB +: 3] != BR_BLANK)
            && !(st.phase_off && (st.cw[CW_BLINK]
            || (st.cw[CW_FLASH] && st.flash[i])));
      end
      next_st.pct = pct_of(st.cw[CW_BR_LSB +: 3]);

      // pin reset: rams, control word and every counter restart together
      if (!dbus.rst_n) begin
         next_st = RST_ST;
      end
   end

   ////////////////////////////////////////////////////////////////
   // state register

   // synchronous system reset, same starting point as the pin reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= RST_ST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs

   // outputs come straight from the state register; busy is decoded from its busy_cnt and st_run fields
   assign dbus.dev_dq_out = st.dout;
   assign dbus.dev_dq_oe = st.doe;
   assign digit_chars = st.chars;
   assign digit_on = st.on;
   assign bright_pct = st.pct;
   assign busy = (st.busy_cnt != 2'h0) || st.st_run;
   assign selftest_run = st.st_run;
endmodule : dcr_device

// >>> core/dcr_host.sv
// host end: axi4-lite command registers driving the display bus
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module dcr_host #(
   parameter int HOLD = dcr_pkg::HOLD_CYC,
   parameter int ST_HOLD = dcr_pkg::ST_HOLD_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   dcr_bus_if.host dbus
);
   import dcr_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_END, H_HOLD} dcr_host_e;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] awa;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [1:0] rr;
      logic [31:0] rd;
      dcr_host_e fsm;
      logic [31:0] cnt;
      logic rst_req;
      logic [16:0] cmd;
      logic [7:0] rd_byte;
      logic rd_done;
   } dcr_host_s;

   dcr_host_s st;
   dcr_host_s next_st;
   logic is_rd;
   logic idle;

   ////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_st = st;
      is_rd = st.cmd[CMD_READ];
      idle = (st.fsm == H_IDLE);
      // write channels, taken in either order
      if (awvalid && awready) begin
         next_st.aw_got = 1'b1;
         next_st.awa = awaddr;
      end
      if (wvalid && wready) begin
         next_st.w_got = 1'b1;
         next_st.wd = wdata;
         next_st.ws = wstrb;
      end
      if (st.bv && bready) begin
         next_st.bv = 1'b0;
      end
      if (st.aw_got && st.w_got && !st.bv) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bv = 1'b1;
         next_st.br = RESP_OKAY;
         if (st.awa == REG_CMD) begin
            // refused while busy or while the display is held in reset
            if (idle && !st.rst_req && (st.ws[2:0] == 3'h7)) begin
               next_st.cmd = st.wd[16:0];
               next_st.fsm = H_SETUP;
               next_st.rd_done = 1'b0;
            end else begin
               next_st.br = RESP_SLVERR;
            end
         end else if (st.awa == REG_CTRL) begin
            if (st.ws[0]) begin
               next_st.rst_req = st.wd[0];
               if (st.wd[0]) begin
                  next_st.fsm = H_IDLE;
               end else if (st.rst_req) begin
                  next_st.fsm = H_HOLD;
                  next_st.cnt = 32'(HOLD);
               end
            end
         end else begin
            next_st.br = RESP_SLVERR;
         end
      end
      // read channel
      if (st.rv && rready) begin
         next_st.rv = 1'b0;
      end
      if (arvalid && arready) begin
         next_st.rv = 1'b1;
         next_st.rr = RESP_OKAY;
         next_st.rd = 32'h00000000;
         unique case (araddr)
            REG_CMD: next_st.rd = {15'h0000, st.cmd};
            REG_CTRL: next_st.rd = {31'h00000000, st.rst_req};
            REG_STAT: next_st.rd = {30'h00000000, st.rd_done, !idle || st.rst_req};
            REG_RDATA: next_st.rd = {24'h000000, st.rd_byte};
            default: next_st.rr = RESP_SLVERR;
         endcase
      end
      // bus cycle sequencer
      unique case (st.fsm)
         H_IDLE: ;
         H_SETUP: begin
            next_st.fsm = H_STROBE;
            next_st.cnt = STROBE_CYC - 32'h1;
         end
         H_STROBE: begin
            if (st.cnt == 32'h0) begin
               next_st.fsm = H_END;
               if (is_rd) begin
                  next_st.rd_byte = dbus.data_bus;
                  next_st.rd_done = 1'b1;
               end
            end else begin
               next_st.cnt = st.cnt - 32'h1;
            end
         end
         H_END: begin
            // stay off the bus while a clear or self test runs
            next_st.fsm = H_IDLE;
            if (!is_rd && st.cmd[CMD_FLN] && (st.cmd[12:11] == SEL_CW)) begin
               if (st.cmd[CW_ST]) begin
                  next_st.fsm = H_HOLD;
                  next_st.cnt = 32'(ST_HOLD);
               end else if (st.cmd[CW_CLEAR]) begin
                  next_st.fsm = H_HOLD;
                  next_st.cnt = 32'(HOLD);
               end
            end
         end
         H_HOLD: begin
            if (st.cnt == 32'h0) begin
               next_st.fsm = H_IDLE;
            end else begin
               next_st.cnt = st.cnt - 32'h1;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // state register

   // the display reset is held from power up until software drops it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         next_st_unused_guard: begin
            st <= '0;
            st.rst_req <= CTRL_RESET_VAL;
            st.fsm <= H_IDLE;
         end
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs

   assign awready = !st.aw_got && !st.bv;
   assign wready = !st.w_got && !st.bv;
   assign bvalid = st.bv;
   assign bresp = st.br;
   assign arready = !st.rv;
   assign rvalid = st.rv;
   assign rresp = st.rr;
   assign rdata = st.rd;
   // pins follow the sequencer state; strobes idle outside a cycle
   assign dbus.rst_n = !st.rst_req;
   assign dbus.ce_n = !(st.fsm == H_SETUP || st.fsm == H_STROBE);
   assign dbus.wr_n = !(st.fsm == H_STROBE && !is_rd);
   assign dbus.rd_n = !(st.fsm == H_STROBE && is_rd);
   assign dbus.flash_ram_select_n = st.cmd[CMD_FLN];
   assign dbus.addr = st.cmd[CMD_ADDR_LSB +: ADDR_W];
   assign dbus.host_dq_out = st.cmd[7:0];
   assign dbus.host_dq_oe = (st.fsm == H_SETUP || st.fsm == H_STROBE) && !is_rd;
endmodule : dcr_host

// >>> test/dcr_link_asserts.sv
// checker of the display bus between the host and display ends
`timescale 1ns/1ns
module dcr_link_asserts #(
   parameter int DCLK_DIV = dcr_pkg::DCLK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rst_n,
   input wire logic ce_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic flash_ram_select_n,
   input wire logic [4:0] addr,
   input wire logic host_dq_oe,
   input wire logic dev_dq_oe,
   input wire logic [7:0] data_bus
);
   import dcr_pkg::*;
   ////////////////////////////////////////////////////////////
   // quiet spans after display reset and after a clear, in clock cycles
   logic [15:0] rst_quiet;
   logic [15:0] clr_quiet;
   logic wr_q;
   always_ff @(posedge aclk) begin
      wr_q <= wr_n;
      if (!aresetn || !rst_n) begin
         rst_quiet <= 16'(CLR_TICKS * DCLK_DIV);
      end else if (rst_quiet != 16'h0) begin
         rst_quiet <= rst_quiet - 16'h1;
      end
      // loads on the write edge; the strobe itself is not a new access
      if (!aresetn) begin
         clr_quiet <= 16'h0;
      end else if (wr_q && !wr_n && flash_ram_select_n && addr[4:3] == SEL_CW && data_bus[CW_CLEAR]) begin
         clr_quiet <= 16'(CLR_TICKS * DCLK_DIV);
      end else if (clr_quiet != 16'h0) begin
         clr_quiet <= clr_quiet - 16'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_strobe_reset_idle: assert property (!rst_n |-> wr_n && rd_n)
      else $error("strobe active while display reset low");
   chk_dev_off_reset: assert property (!rst_n |=> !dev_dq_oe)
      else $error("display drives data while held in reset");
   chk_quiet_after_reset: assert property (rst_quiet != 16'h0 |-> !$fell(wr_n) && !$fell(rd_n))
      else $error("access during reset period");
   chk_quiet_after_clear: assert property (clr_quiet != 16'h0 |-> !$fell(wr_n) && !$fell(rd_n))
      else $error("access during clear");
   chk_write_width: assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n)
      else $error("write strobe width wrong");
   chk_read_driven: assert property ($fell(rd_n) |=> dev_dq_oe [*3])
      else $error("display did not drive read data");
   chk_strobe_framed: assert property ((!wr_n || !rd_n) |-> !ce_n && !$past(ce_n))
      else $error("strobe without chip enable set up");
   chk_write_data_out: assert property (!wr_n |-> host_dq_oe && !dev_dq_oe)
      else $error("write data not driven by host alone");
endmodule : dcr_link_asserts

// >>> test/display_control_and_reset_tb.sv
// self-checking bench joining host and display ends over one bus
`timescale 1ns/1ns
module display_control_and_reset_tb;
   import dcr_pkg::*;
   localparam int DIV = 4;
   localparam int FPER = 8;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, digit_on;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   dcr_chars_t digit_chars;
   logic [6:0] bright_pct;
   logic busy, selftest_run;
   int failures, tests_run;
   logic [6:0] exp_chars [8];
   dcr_bus_if dbus_i(); // one clock and one reset feed both ends
   dcr_host #(.HOLD(20), .ST_HOLD(40)) u_dcr_host (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .dbus(dbus_i));
   dcr_device #(.DCLK_DIV(DIV), .FLASH_PERIOD(FPER), .SELFTEST_TICKS(4)) u_dcr_device (.aclk, .aresetn,
      .dbus(dbus_i), .digit_chars, .digit_on, .bright_pct, .busy, .selftest_run);
   dcr_link_asserts #(.DCLK_DIV(DIV)) u_dcr_link_asserts (.aclk, .aresetn, .rst_n(dbus_i.rst_n),
      .ce_n(dbus_i.ce_n), .wr_n(dbus_i.wr_n), .rd_n(dbus_i.rd_n), .flash_ram_select_n(dbus_i.flash_ram_select_n),
      .addr(dbus_i.addr), .host_dq_oe(dbus_i.host_dq_oe), .dev_dq_oe(dbus_i.dev_dq_oe), .data_bus(dbus_i.data_bus));
   ////////////////////////////////////////////////////////////
   // clock and hang guard; a hang counts as a mismatch
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      repeat (40000) @(posedge aclk);
      failures++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////
   // expectations
   function automatic logic [6:0] pct_of(input logic [2:0] code);
      logic [6:0] tab [8] = '{7'h64, 7'h50, 7'h35, 7'h28, 7'h1b, 7'h14, 7'h0d, 7'h00};
      return tab[code];
   endfunction : pct_of
   function automatic dcr_chars_t pack_chars();
      dcr_chars_t p;
      for (int i = 0; i < 8; i++) p[i] = exp_chars[i];
      return p;
   endfunction : pack_chars
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////
   // axi4-lite master: hold each channel until its own handshake
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : axi_read
   // polls status until the host sequencer is idle again
   task automatic wait_idle();
      logic [31:0] v;
      logic [1:0] r;
      for (int n = 0; n < 200; n++) begin
         axi_read(REG_STAT, v, r);
         if (v[0] === 1'b0) break;
      end
      check(v[0], 1'b0);
   endtask : wait_idle
   // one display bus cycle through the command register
   task automatic dbus_op(input logic fl, input logic [4:0] a, input logic [7:0] d, input logic rd_op,
      output logic [7:0] q);
      logic [31:0] v;
      logic [1:0] r;
      axi_write(REG_CMD, {15'h0, rd_op, 2'h0, fl, a, d}, 4'hf, r);
      check(r, RESP_OKAY);
      wait_idle();
      axi_read(REG_RDATA, v, r);
      q = v[7:0];
   endtask : dbus_op
   // counts cycles of display busy, both waits bounded
   task automatic busy_len(output int c);
      c = 0;
      while (busy !== 1'b1 && c < 30) begin
         @(posedge aclk);
         c++;
      end
      c = 0;
      while (busy === 1'b1 && c < 100) begin
         @(posedge aclk);
         c++;
      end
   endtask : busy_len
   // counts cycles with any digit dark over two blink periods
   task automatic watch(input logic [7:0] fmask, output int offc);
      offc = 0;
      for (int n = 0; n < 2 * FPER * DIV; n++) begin
         @(negedge aclk);
         if (digit_on !== 8'hff) offc++;
         if (digit_on !== 8'hff && digit_on !== ~fmask) offc += 1000;
      end
   endtask : watch
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] v;
      logic [1:0] r;
      logic [7:0] q;
      logic [7:0] fmask;
      logic [7:0] mode_cw [4];
      int c;
      v = $urandom(20736);
      mode_cw = '{8'h00, 8'h08, 8'h18, 8'h10};
      failures = 0;
      tests_run = 0;
      aresetn = 1'b0;
      {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++) exp_chars[i] = SPACE_CODE;
      axi_read(REG_CTRL, v, r);
      check(v, 32'h1);
      axi_write(8'h40, 32'h0, 4'hf, r);
      check(r, RESP_SLVERR);
      axi_read(8'h44, v, r);
      check(r, RESP_SLVERR);
      axi_write(REG_CTRL, 32'h0, 4'hf, r);
      busy_len(c);
      check(c >= 3 * DIV - 2 && c <= 3 * DIV + 2, 1'b1);
      wait_idle();
      check(digit_chars, pack_chars());
      dbus_op(1'b1, 5'h10, 8'h00, 1'b1, q);
      check(q, CW_RESET);
      // every brightness code, blank included
      for (int i = 0; i < 8; i++) begin
         dbus_op(1'b1, 5'h10, {5'h0, i[2:0]}, 1'b0, q);
         check(bright_pct, pct_of(i[2:0]));
         check(digit_on, (i == 7) ? 8'h00 : 8'hff);
      end
      // random ascii into every digit, read back over the bus
      for (int i = 0; i < 8; i++) begin
         exp_chars[i] = 7'($urandom_range(126, 32));
         dbus_op(1'b1, {2'h3, i[2:0]}, {1'b0, exp_chars[i]}, 1'b0, q);
      end
      check(digit_chars, pack_chars());
      for (int i = 0; i < 8; i++) begin
         dbus_op(1'b1, {2'h3, i[2:0]}, 8'h00, 1'b1, q);
         check(q, {1'b0, exp_chars[i]});
      end
      // flash marks, then flash off, flash on, blink with flash, blink alone
      fmask = {1'b0, 6'($urandom()), 1'b1};
      for (int i = 0; i < 8; i++) dbus_op(1'b0, {2'h0, i[2:0]}, {7'h0, fmask[i]}, 1'b0, q);
      for (int i = 0; i < 4; i++) begin
         dbus_op(1'b1, 5'h10, mode_cw[i], 1'b0, q);
         watch((i < 2) ? fmask : 8'hff, c);
         check(c, (i == 0) ? 0 : FPER * DIV);
      end
      // control word writes with bit seven low leave the characters alone
      check(digit_chars, pack_chars());
      // clear keeps the low bits and drops the clear bit itself
      axi_write(REG_CMD, {18'h0, 1'b1, 5'h10, 8'h8b}, 4'hf, r);
      busy_len(c);
      check(c >= 2 * DIV && c <= 3 * DIV + 1, 1'b1);
      // host still holding off after the clear, so a new command is refused
      axi_write(REG_CMD, {18'h0, 1'b1, 5'h10, 8'h00}, 4'hf, r);
      check(r, RESP_SLVERR);
      wait_idle();
      for (int i = 0; i < 8; i++) exp_chars[i] = SPACE_CODE;
      check(digit_chars, pack_chars());
      dbus_op(1'b1, 5'h10, 8'h00, 1'b1, q);
      check(q, 8'h0b);
      dbus_op(1'b0, 5'h00, 8'h00, 1'b1, q);
      check(q, 8'h00);
      watch(fmask, c);
      check(c, 0);
      // self test blanks the rams and reports a pass
      dbus_op(1'b1, 5'h1b, 8'h41, 1'b0, q);
      dbus_op(1'b1, 5'h10, 8'h40, 1'b0, q);
      check(digit_chars, pack_chars());
      dbus_op(1'b1, 5'h10, 8'h00, 1'b1, q);
      check(q, 8'h20);
      dbus_op(1'b1, 5'h10, 8'h05, 1'b0, q);
      dbus_op(1'b1, 5'h10, 8'h00, 1'b1, q);
      check(q, 8'h25);
      // display reset in mid-run
      dbus_op(1'b1, 5'h1a, 8'h41, 1'b0, q);
      dbus_op(1'b0, 5'h02, 8'h01, 1'b0, q);
      axi_write(REG_CTRL, 32'h1, 4'hf, r);
      axi_write(REG_CTRL, 32'h0, 4'hf, r);
      busy_len(c);
      check(c >= 3 * DIV - 2 && c <= 3 * DIV + 2, 1'b1);
      wait_idle();
      check(digit_chars, pack_chars());
      dbus_op(1'b1, 5'h10, 8'h00, 1'b1, q);
      check(q, 8'h00);
      dbus_op(1'b1, 5'h10, 8'h08, 1'b0, q);
      watch(8'h00, c);
      check(c, 0);
      stop_test();
   end
endmodule : display_control_and_reset_tb
